/* File: dv/interlock_monitor.sv */
`timescale 1ns/1ns
module interlock_monitor (
  // Watched ports.
  input wire clk_sys, input wire rstn, input wire chan_a_closed, input wire chan_short_fault,
  input wire error_in, input wire main_power_enable_r, input wire main_power_on_status_r,
  input wire error_latched_r, input wire fault_block_r, input wire beam_channel_open_feedback_r,
  input wire beam_channel_closed_feedback_r, input wire [3:0] gate_channel_code_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_st; main_power_on_status_r == main_power_enable_r; endproperty
  a_st: assert property (p_st) else $error("status");
  property p_er; error_in |=> !main_power_enable_r && error_latched_r; endproperty
  a_er: assert property (p_er) else $error("error");
  property p_lt; error_latched_r |-> !main_power_enable_r; endproperty
  a_lt: assert property (p_lt) else $error("latch");
  property p_op; !chan_a_closed [*8] |=> !main_power_enable_r; endproperty
  a_op: assert property (p_op) else $error("open");
  property p_on; $rose(main_power_enable_r) |-> chan_a_closed && !error_latched_r; endproperty
  a_on: assert property (p_on) else $error("start");
  property p_sh; chan_short_fault |=> fault_block_r; endproperty
  a_sh: assert property (p_sh) else $error("short");
  property p_fb; beam_channel_open_feedback_r |-> !beam_channel_closed_feedback_r; endproperty
  a_fb: assert property (p_fb) else $error("feedback");
  property p_cd; gate_channel_code_r != 4'h0 |-> beam_channel_open_feedback_r; endproperty
  a_cd: assert property (p_cd) else $error("code");
  c_on: cover property ($rose(main_power_enable_r));
  c_er: cover property ($rose(error_latched_r));
  c_sh: cover property ($rose(fault_block_r));
endmodule // interlock_monitor

/* File: dv/plc_model.sv */
`timescale 1ns/1ns
module plc_model (
  // Clock, reset and block side.
  input wire clk_sys, input wire rstn, input wire main_power_enable_r, input wire [3:0] tgt,
  input wire hop, input wire mon_fail,
  output wire power_monitor, output reg [3:0] sel, output wire beam_switch_is_open
);
  // Contactor echoes the enable at once, so monitoring never sees a stale mismatch.
  assign power_monitor = main_power_enable_r ^ mon_fail;
  assign beam_switch_is_open = (sel != 4'h0);
  // Unless hop is set, every change passes through code zero first; with hop the code jumps straight to tgt.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) sel <= 4'h0;
    else if (sel != tgt) sel <= (hop || sel == 4'h0) ? tgt : 4'h0;
  end
endmodule // plc_model

/* File: dv/tb.sv */
`timescale 1ns/1ns
module tb;
  reg clk_sys = 1'b0, rstn = 1'b0, chan_a_closed = 1'b0, chan_b_closed = 1'b0, chan_short_fault = 1'b0;
  reg start_button = 1'b0, stop_button = 1'b0, manual_reset = 1'b0, error_in = 1'b0;
  reg [3:0] tgt = 4'h0;
  reg hop = 1'b0, mon_fail = 1'b0;
  wire power_monitor, beam_switch_is_open, main_power_enable_r, main_power_on_status_r, error_latched_r;
  wire fault_block_r, beam_channel_open_feedback_r, beam_channel_closed_feedback_r, sequence_error_r;
  wire [3:0] sel, gate_channel_code_r;
  integer failures = 0, total_checks = 0;
  initial forever #4 clk_sys = ~clk_sys;
  plc_model i_plc (.clk_sys, .rstn, .main_power_enable_r, .tgt, .hop, .mon_fail, .power_monitor, .sel,
    .beam_switch_is_open);
  safety_interlock #(.DEBOUNCE(32'h4), .START_STUCK(32'h32)) i_dut (.*, .beam_channel_select_inputs(sel));
  task cyc(input integer n); repeat (n) @(posedge clk_sys); endtask
  task chk(input ok); begin
    total_checks = total_checks + 1;
    if (ok !== 1'b1) begin failures = failures + 1; $display("ERROR %0t check %0d", $time, total_checks); end
  end endtask
  // Both channels open together, then close, which re-arms the start.
  task arm; begin
    chan_a_closed <= 1'b0; chan_b_closed <= 1'b0; cyc(12);
    chan_a_closed <= 1'b1; chan_b_closed <= 1'b1; cyc(12);
  end endtask
  task press; begin start_button <= 1'b1; cyc(12); start_button <= 1'b0; cyc(12); end endtask
  task clr; begin manual_reset <= 1'b1; cyc(12); manual_reset <= 1'b0; cyc(12); end endtask
  task t_start; begin
    arm; press;
    chk(main_power_enable_r === 1'b1 && main_power_on_status_r === 1'b1);
    $display("t_start done");
  end endtask
  task t_one; begin
    chan_a_closed <= 1'b0; cyc(12);
    chk(main_power_enable_r === 1'b0 && main_power_on_status_r === 1'b0);
    chan_a_closed <= 1'b1; cyc(12); press;
    chk(main_power_enable_r === 1'b0);
    arm; press;
    chk(main_power_enable_r === 1'b1);
    $display("t_one done");
  end endtask
  task t_err; begin
    error_in <= 1'b1; cyc(1); error_in <= 1'b0; cyc(2);
    chk(error_latched_r === 1'b1 && main_power_enable_r === 1'b0);
    arm; press;
    chk(main_power_enable_r === 1'b0);
    clr; arm; press;
    chk(error_latched_r === 1'b0 && main_power_enable_r === 1'b1);
    $display("t_err done");
  end endtask
  task t_short; begin
    chan_short_fault <= 1'b1; clr; arm; press;
    chk(fault_block_r === 1'b1 && main_power_enable_r === 1'b0);
    chan_short_fault <= 1'b0; cyc(2); clr; arm; press;
    chk(fault_block_r === 1'b0 && main_power_enable_r === 1'b1);
    $display("t_short done");
  end endtask
  task t_beam; begin
    tgt <= 4'h2; cyc(8);
    chk(gate_channel_code_r === 4'h2 && beam_channel_open_feedback_r === 1'b1);
    tgt <= 4'h3; cyc(8);
    chk(gate_channel_code_r === 4'h3 && sequence_error_r === 1'b0);
    tgt <= 4'h0; cyc(8);
    chk(gate_channel_code_r === 4'h0 && beam_channel_closed_feedback_r === 1'b1);
    $display("t_beam done");
  end endtask
  task t_stop; begin
    stop_button <= 1'b1; cyc(12);
    chk(main_power_enable_r === 1'b0 && main_power_on_status_r === 1'b0);
    press;
    chk(main_power_enable_r === 1'b0);
    stop_button <= 1'b0; arm; press;
    chk(main_power_enable_r === 1'b1);
    $display("t_stop done");
  end endtask
  task t_stuck; begin
    start_button <= 1'b1; cyc(70);
    chk(fault_block_r === 1'b1 && error_latched_r === 1'b1 && main_power_enable_r === 1'b0);
    clr;
    chk(error_latched_r === 1'b1);
    start_button <= 1'b0; cyc(12); clr;
    chk(fault_block_r === 1'b0 && error_latched_r === 1'b0);
    $display("t_stuck done");
  end endtask
  task t_mon; begin
    arm; press;
    chk(main_power_enable_r === 1'b1);
    mon_fail <= 1'b1; cyc(2); mon_fail <= 1'b0; cyc(2);
    chk(error_latched_r === 1'b1 && main_power_enable_r === 1'b0);
    clr;
    chk(error_latched_r === 1'b0);
    $display("t_mon done");
  end endtask
  task t_seq; begin
    hop <= 1'b1; tgt <= 4'h1; cyc(4); tgt <= 4'h3; cyc(4);
    chk(sequence_error_r === 1'b1 && gate_channel_code_r === 4'h3);
    hop <= 1'b0; tgt <= 4'h0; cyc(4); clr;
    chk(sequence_error_r === 1'b0 && gate_channel_code_r === 4'h0);
    $display("t_seq done");
  end endtask
  task summarize; begin
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end endtask
  initial begin
    cyc(8); rstn <= 1'b1; cyc(4);
    t_start; t_one; t_err; t_short; t_beam; t_stop; t_stuck; t_mon; t_seq;
    summarize;
  end
  // A hang counts as a mismatch and goes to the same report.
  initial begin cyc(5000); failures = failures + 1; summarize; end
endmodule // tb
bind safety_interlock interlock_monitor i_mon (.*);

/* File: include/interlock_defines.vh */
`ifndef INTERLOCK_DEFINES_VH
`define INTERLOCK_DEFINES_VH
`define CLK_PERIOD_NS 8
`define DEBOUNCE_TIME_NS 1000000
`define DEBOUNCE_CYCLES ((`DEBOUNCE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define START_STUCK_TIME_NS 2000000000
`define START_STUCK_CYCLES (`START_STUCK_TIME_NS / `CLK_PERIOD_NS)
`define GATE_CODE_W 4
`define GATE_CODE_CLOSED 4'h0
`define SEL_W 4
`endif

/* File: rtl/input_filter.v */
`timescale 1ns/1ns
`include "interlock_defines.vh"
module input_filter #(
  parameter [31:0] DEBOUNCE = 32'd125000
) (
  // Clock and reset.
  input wire clk_sys,
  input wire rstn,
  // Raw and filtered level.
  input wire raw,
  output reg clean_r
);
  reg meta_r;
  reg sync_r;
  reg [31:0] cnt_r;

  // Two stages of synchroniser, then a stability counter.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      cnt_r <= 32'h0;
      clean_r <= 1'b0;
    end else begin
      meta_r <= raw;
      sync_r <= meta_r;
      if (sync_r == clean_r) begin
        cnt_r <= 32'h0;
      end else if (cnt_r >= DEBOUNCE - 32'd1) begin
        cnt_r <= 32'h0;
        clean_r <= sync_r;
      end else begin
        cnt_r <= cnt_r + 32'd1;
      end
    end
  end
endmodule // input_filter

/* File: rtl/safety_interlock.v */
`timescale 1ns/1ns
`include "interlock_defines.vh"
module safety_interlock #(
  parameter [31:0] DEBOUNCE = `DEBOUNCE_CYCLES,
  parameter [31:0] START_STUCK = `START_STUCK_CYCLES
) (
  // Clock and reset.
  input wire clk_sys,
  input wire rstn,
  // Interlock channels, high when closed.
  input wire chan_a_closed,
  input wire chan_b_closed,
  // Short detector between the two channels, high on fault.
  input wire chan_short_fault,
  // Buttons, high when pressed.
  input wire start_button,
  input wire stop_button,
  input wire manual_reset,
  // External error detectors, high while an error is present.
  input wire error_in,
  // Monitoring of the main power contactor, high when contactor is closed.
  input wire power_monitor,
  // Beam switch.
  input wire [`SEL_W-1:0] beam_channel_select_inputs,
  input wire beam_switch_is_open,
  // Outputs.
  output reg main_power_enable_r,
  output reg main_power_on_status_r,
  output reg error_latched_r,
  output reg fault_block_r,
  output reg beam_channel_open_feedback_r,
  output reg beam_channel_closed_feedback_r,
  output reg [`GATE_CODE_W-1:0] gate_channel_code_r,
  output reg sequence_error_r
);
  wire a_c;
  wire b_c;
  wire start_c;
  wire stop_c;
  wire reset_c;
  wire [4:0] raw_v;
  wire [4:0] clean_v;
  reg start_d_r;
  reg reset_d_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [31:0] stuck_cnt_r;
  reg start_stuck_r;
  reg mon_mismatch_r;
  reg [`SEL_W-1:0] last_sel_r;
  wire start_edge;
  wire reset_edge;
  wire both_closed;
  wire any_open;
  wire err_now;
  wire fault_now;
  // Power sequencing states; only ST_ON closes the contactor.
  localparam [1:0] ST_BLOCKED = 2'h0;
  localparam [1:0] ST_ARMED = 2'h1;
  localparam [1:0] ST_ON = 2'h2;

  assign raw_v = {manual_reset, stop_button, start_button, chan_b_closed, chan_a_closed};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_filt
      input_filter #(.DEBOUNCE(DEBOUNCE)) u_filt (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .raw(raw_v[gi]),
        .clean_r(clean_v[gi])
      );
    end
  endgenerate

  assign a_c = clean_v[0];
  assign b_c = clean_v[1];
  assign start_c = clean_v[2];
  assign stop_c = clean_v[3];
  assign reset_c = clean_v[4];
  assign start_edge = start_c & ~start_d_r;
  assign reset_edge = reset_c & ~reset_d_r;
  assign both_closed = a_c & b_c;
  assign any_open = ~a_c | ~b_c;
  assign fault_now = chan_short_fault | start_stuck_r;
  // Power monitor disagreeing with the enable a cycle later counts as an error.
  assign err_now = error_in | mon_mismatch_r | fault_now;

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      start_d_r <= 1'b0;
      reset_d_r <= 1'b0;
      stuck_cnt_r <= 32'h0;
      start_stuck_r <= 1'b0;
    end else begin
      start_d_r <= start_c;
      reset_d_r <= reset_c;
      // A start held far longer than any press is taken as a shorted button.
      if (!start_c) begin
        stuck_cnt_r <= 32'h0;
        start_stuck_r <= 1'b0;
      end else if (stuck_cnt_r >= START_STUCK - 32'd1) begin
        start_stuck_r <= 1'b1;
      end else begin
        stuck_cnt_r <= stuck_cnt_r + 32'd1;
      end
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mon_mismatch_r <= 1'b0;
      fault_block_r <= 1'b0;
    end else begin
      mon_mismatch_r <= (power_monitor != main_power_enable_r) &&
        (main_power_enable_r == main_power_on_status_r);
      fault_block_r <= fault_now;
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      error_latched_r <= 1'b0;
    end else begin
      // Setting wins over the manual reset, so an error present during reset stays held.
      if (err_now) begin
        error_latched_r <= 1'b1;
      end else if (reset_edge && !fault_block_r) begin
        error_latched_r <= 1'b0;
      end
    end
  end

  // Arming needs both channels open at once; a single open channel never rearms.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_BLOCKED: begin
        if (!a_c && !b_c) begin
          state_nxt = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (start_edge && both_closed && !stop_c && !err_now && !error_latched_r) begin
          state_nxt = ST_ON;
        end
      end
      ST_ON: begin
        if (any_open || err_now || error_latched_r || stop_c) begin
          state_nxt = (!a_c && !b_c) ? ST_ARMED : ST_BLOCKED;
        end
      end
      default: begin
        state_nxt = ST_BLOCKED;
      end
    endcase
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_BLOCKED;
      main_power_enable_r <= 1'b0;
      main_power_on_status_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // Both outputs follow one next state, so the status can never lag the enable.
      main_power_enable_r <= (state_nxt == ST_ON);
      main_power_on_status_r <= (state_nxt == ST_ON);
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      beam_channel_open_feedback_r <= 1'b0;
      beam_channel_closed_feedback_r <= 1'b0;
      gate_channel_code_r <= `GATE_CODE_CLOSED;
    end else begin
      beam_channel_open_feedback_r <= beam_switch_is_open;
      beam_channel_closed_feedback_r <= ~beam_switch_is_open;
      gate_channel_code_r <= beam_switch_is_open ? beam_channel_select_inputs : `GATE_CODE_CLOSED;
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      last_sel_r <= `GATE_CODE_CLOSED;
      sequence_error_r <= 1'b0;
    end else begin
      // Flag a direct hop between two open channels without passing channel zero.
      last_sel_r <= beam_channel_select_inputs;
      if (beam_channel_select_inputs != last_sel_r && last_sel_r != `GATE_CODE_CLOSED &&
          beam_channel_select_inputs != `GATE_CODE_CLOSED) begin
        sequence_error_r <= 1'b1;
      end else if (reset_edge) begin
        sequence_error_r <= 1'b0;
      end
    end
  end
endmodule // safety_interlock
